// >>> hcf_cfg.svh
// Offsets, field positions, reset values and the summary of the flag bank
//--------------------------------------------------------------------
// How it works
// - Set and clear addresses share one flag set
// - Company code register is fixed, writes ignored
// - Image valid lets ROM block reads answer
// - Image invalid answers ROM block reads with error
// - Bus reset with invalid image reloads nothing
// - Image valid cleared only by resets, fetch error
// - Swap-disable flag controls byte swap of DMA data
// - Late-ack permit answers async packets with ack_tardy
// - Every ack_tardy raises the late-ack event
// - Flag bits 28 to 24 read zero
// - PHY-setup bit tells driver may configure PHY
// - PHY-setup bit loads from EEPROM, defaults one
// - PHY-setup bit changed only by global reset, EEPROM load
// - Link off drops block reads and async packets at once
//--------------------------------------------------------------------
`ifndef HCF_CFG_SVH
`define HCF_CFG_SVH

// Register byte offsets
`define HCF_OFS_COMPANY 8'h40
`define HCF_OFS_SET 8'h50
`define HCF_OFS_CLR 8'h54

// Flag bit positions
`define HCF_BIT_IMG 31
`define HCF_BIT_SWAP 30
`define HCF_BIT_LATE 29
`define HCF_BIT_PSET 23
`define HCF_BIT_PEXT 22
`define HCF_BIT_LINK 17
`define HCF_BIT_SRST 16

// Reset values
`define HCF_RST_FLAG 1'b0
`define HCF_RST_PSET 1'b1
`define HCF_ZERO32 32'h0000_0000

`endif

// >>> hcf_pkg.sv
// Types and shared helper functions of the host control flag bank
`include "hcf_cfg.svh"
package hcf_pkg;

   //-----------------------------------------------------------------
   // Types
   //-----------------------------------------------------------------
   // Flag set as seen through the set and clear addresses
   typedef struct packed {
      logic img_valid;
      logic swap_dis;
      logic late_ack;
      logic phy_setup;
      logic phy_ext;
      logic link_on;
      logic soft_rst;
   } hcf_flags_t;

   // Events arriving from the serial bus side, one-cycle pulses
   typedef struct packed {
      logic blk_rd;
      logic async_req;
      logic bus_reset;
      logic fetch_err;
   } hcf_link_ev_t;

   // Slave phase, Gray along idle to answer
   typedef enum logic [1:0] {
      BS_IDLE = 2'b00,
      BS_ANSWER = 2'b01
   } hcf_bus_st_t;

   //-----------------------------------------------------------------
   // Functions
   //-----------------------------------------------------------------
   // Word hit on an aligned offset
   function automatic logic hcf_hit(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction

   // Byte enables widened to a bit mask
   function automatic logic [31:0] hcf_lane_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // Set wins over clear
   function automatic logic hcf_rsc(input logic cur, input logic set, input logic clr);
      return set ? 1'b1 : (clr ? 1'b0 : cur);
   endfunction

   // Flag word; every other bit stays zero
   function automatic logic [31:0] hcf_pack(input hcf_flags_t f);
      logic [31:0] w;
      w = `HCF_ZERO32;
      w[`HCF_BIT_IMG] = f.img_valid;
      w[`HCF_BIT_SWAP] = f.swap_dis;
      w[`HCF_BIT_LATE] = f.late_ack;
      w[`HCF_BIT_PSET] = f.phy_setup;
      w[`HCF_BIT_PEXT] = f.phy_ext;
      w[`HCF_BIT_LINK] = f.link_on;
      w[`HCF_BIT_SRST] = f.soft_rst;
      return w;
   endfunction

   // Quadlet byte reversal
   function automatic logic [31:0] hcf_bswap(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

endpackage

// >>> hcf_swap.sv
// Registered byte-swap stage for DMA and physical data
`timescale 1ns/1ns
`include "hcf_cfg.svh"
module hcf_swap
   import hcf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic swap_dis_i,
   // Data in
   input wire logic [31:0] data_i,
   input wire logic valid_i,
   input wire logic outside_i,
   // Data out
   output logic [31:0] data_o,
   output logic valid_o
);

   //-----------------------------------------------------------------
   // Swap stage
   //-----------------------------------------------------------------
   // Internal locations never swap; one register stage keeps timing
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o <= `HCF_ZERO32;
         valid_o <= 1'b0;
      end else begin
         valid_o <= valid_i;
         if (valid_i) begin
            data_o <= (outside_i && !swap_dis_i) ? hcf_bswap(data_i) : data_i;
         end
      end
   end

   //-----------------------------------------------------------------
   // Checks
   //-----------------------------------------------------------------
   a_swap_applied: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && outside_i && !swap_dis_i) |=> (data_o == hcf_bswap($past(data_i))))
      else $error("outside data not swapped");

   a_swap_bypass: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && (swap_dis_i || !outside_i)) |=> (data_o == $past(data_i)))
      else $error("data swapped when it must pass");

endmodule

// >>> hcf_regs.sv
// Host control flag register bank with Avalon-MM slave and link-side decisions
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "hcf_cfg.svh"
module hcf_regs
   import hcf_pkg::*;
#(
   // Arbitrary value, stands in for the maker code
   parameter logic [31:0] COMPANY_CODE = 32'h00a5_0c0d
)(
   // Clock and resets
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic SYS_RESET_I,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Serial bus events and EEPROM load
   input wire hcf_link_ev_t LINK_EV_I,
   input wire logic EE_LOAD_I,
   input wire logic EE_PHY_SETUP_I,
   // DMA data path
   input wire logic [31:0] DMA_DATA_I,
   input wire logic DMA_VALID_I,
   input wire logic DMA_OUTSIDE_I,
   output logic [31:0] DMA_DATA_O,
   output logic DMA_VALID_O,
   // Responses to the serial bus side
   output logic ROM_RD_ACCEPT_O,
   output logic ROM_TYPE_ERR_O,
   output logic ROM_RELOAD_O,
   output logic TARDY_ACK_O,
   output logic TARDY_EVENT_O,
   output logic ASYNC_PASS_O,
   // Flag state
   output logic ROM_UPDATE_EN_O,
   output logic LINK_CONNECT_O,
   output logic PHY_EXT_ON_O,
   output logic PHY_SETUP_O
);

   //-----------------------------------------------------------------
   // Declarations
   //-----------------------------------------------------------------
   hcf_bus_st_t bus_st_ff;
   hcf_bus_st_t nxt_bus_st;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rd_word;
   logic img_valid_ff;
   logic swap_dis_ff;
   logic late_ack_ff;
   logic phy_setup_ff;
   logic phy_ext_ff;
   logic link_on_ff;
   logic soft_rst_ff;
   logic rom_acc_ff;
   logic rom_err_ff;
   logic rom_reload_ff;
   logic tardy_ff;
   logic tardy_ev_ff;
   logic pass_ff;
   logic req;
   logic in_answer;
   logic wr_set;
   logic wr_clr;
   logic hw_clr;
   logic [31:0] wmask;
   logic [31:0] flags_word;
   hcf_flags_t flags;

   //-----------------------------------------------------------------
   // Bus decode
   //-----------------------------------------------------------------
   // A write lands only in the answer cycle, when waitrequest is low
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign in_answer = (bus_st_ff == BS_ANSWER);
   assign wmask = AVS_WRITEDATA_I & hcf_lane_mask(AVS_BYTEENABLE_I);
   assign wr_set = in_answer & AVS_WRITE_I & hcf_hit(AVS_ADDRESS_I, `HCF_OFS_SET);
   assign wr_clr = in_answer & AVS_WRITE_I & hcf_hit(AVS_ADDRESS_I, `HCF_OFS_CLR);

   // System reset and the self-clearing soft reset clear the same flags
   assign hw_clr = SYS_RESET_I | soft_rst_ff;

   // Flag view shared by both addresses
   always_comb begin
      flags.img_valid = img_valid_ff;
      flags.swap_dis = swap_dis_ff;
      flags.late_ack = late_ack_ff;
      flags.phy_setup = phy_setup_ff;
      flags.phy_ext = phy_ext_ff;
      flags.link_on = link_on_ff;
      flags.soft_rst = soft_rst_ff;
   end

   // Reserved and low bits are never placed in the word
   assign flags_word = hcf_pack(flags);

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rd_word = `HCF_ZERO32;
      if (hcf_hit(AVS_ADDRESS_I, `HCF_OFS_COMPANY)) begin
         rd_word = COMPANY_CODE;
      end else if (hcf_hit(AVS_ADDRESS_I, `HCF_OFS_SET) ||
                   hcf_hit(AVS_ADDRESS_I, `HCF_OFS_CLR)) begin
         rd_word = flags_word;
      end
   end

   //-----------------------------------------------------------------
   // Slave handshake
   //-----------------------------------------------------------------
   // Idle sees a request, answer drops waitrequest for one cycle
   always_comb begin
      case (bus_st_ff)
         BS_IDLE: begin
            nxt_bus_st = req ? BS_ANSWER : BS_IDLE;
         end
         BS_ANSWER: begin
            nxt_bus_st = BS_IDLE;
         end
         default: begin
            nxt_bus_st = BS_IDLE;
         end
      endcase
   end

   // Phase register
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bus_st_ff <= BS_IDLE;
      end else begin
         bus_st_ff <= nxt_bus_st;
      end
   end

   // Waitrequest held high outside the answer cycle
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= (nxt_bus_st != BS_ANSWER);
      end
   end

   // Read data captured one cycle early so the output is a flop
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rdata_ff <= `HCF_ZERO32;
      end else if (bus_st_ff == BS_IDLE && AVS_READ_I) begin
         rdata_ff <= rd_word;
      end
   end

   //-----------------------------------------------------------------
   // Flags
   //-----------------------------------------------------------------
   // Image valid: set only with link off, no clear address effect
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         img_valid_ff <= `HCF_RST_FLAG;
      end else if (hw_clr) begin
         img_valid_ff <= 1'b0;
      end else if (wr_set && wmask[`HCF_BIT_IMG] && !link_on_ff) begin
         img_valid_ff <= 1'b1;
      end else if (LINK_EV_I.fetch_err) begin
         img_valid_ff <= 1'b0;
      end
   end

   // Swap disable survives ordinary resets
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         swap_dis_ff <= `HCF_RST_FLAG;
      end else begin
         swap_dis_ff <= hcf_rsc(swap_dis_ff, wr_set & wmask[`HCF_BIT_SWAP],
                                wr_clr & wmask[`HCF_BIT_SWAP]);
      end
   end

   // Late-ack permit
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         late_ack_ff <= `HCF_RST_FLAG;
      end else if (hw_clr) begin
         late_ack_ff <= 1'b0;
      end else begin
         late_ack_ff <= hcf_rsc(late_ack_ff, wr_set & wmask[`HCF_BIT_LATE],
                                wr_clr & wmask[`HCF_BIT_LATE]);
      end
   end

   // PHY extensions on
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         phy_ext_ff <= `HCF_RST_FLAG;
      end else if (hw_clr) begin
         phy_ext_ff <= 1'b0;
      end else begin
         phy_ext_ff <= hcf_rsc(phy_ext_ff, wr_set & wmask[`HCF_BIT_PEXT],
                               wr_clr & wmask[`HCF_BIT_PEXT]);
      end
   end

   // Link on; clearing it cuts the serial bus from the next edge
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         link_on_ff <= `HCF_RST_FLAG;
      end else if (hw_clr) begin
         link_on_ff <= 1'b0;
      end else begin
         link_on_ff <= hcf_rsc(link_on_ff, wr_set & wmask[`HCF_BIT_LINK],
                               wr_clr & wmask[`HCF_BIT_LINK]);
      end
   end

   // Soft reset reads one for the single cycle it takes
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         soft_rst_ff <= `HCF_RST_FLAG;
      end else begin
         soft_rst_ff <= wr_set & wmask[`HCF_BIT_SRST] & !soft_rst_ff;
      end
   end

   // PHY setup: read-only, global reset or EEPROM load only
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         phy_setup_ff <= `HCF_RST_PSET;
      end else if (EE_LOAD_I) begin
         phy_setup_ff <= EE_PHY_SETUP_I;
      end
   end

   //-----------------------------------------------------------------
   // Serial bus responses
   //-----------------------------------------------------------------
   // ROM block reads: accept or type error, nothing with link off
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rom_acc_ff <= 1'b0;
         rom_err_ff <= 1'b0;
      end else begin
         rom_acc_ff <= link_on_ff & LINK_EV_I.blk_rd & img_valid_ff;
         rom_err_ff <= link_on_ff & LINK_EV_I.blk_rd & !img_valid_ff;
      end
   end

   // Bus reset reloads ROM mapping only with a valid image
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rom_reload_ff <= 1'b0;
      end else begin
         rom_reload_ff <= LINK_EV_I.bus_reset & img_valid_ff;
      end
   end

   // Async packets: ack_tardy and its event always travel together
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tardy_ff <= 1'b0;
         tardy_ev_ff <= 1'b0;
         pass_ff <= 1'b0;
      end else begin
         tardy_ff <= link_on_ff & LINK_EV_I.async_req & late_ack_ff;
         tardy_ev_ff <= link_on_ff & LINK_EV_I.async_req & late_ack_ff;
         pass_ff <= link_on_ff & LINK_EV_I.async_req & !late_ack_ff;
      end
   end

   //-----------------------------------------------------------------
   // Data path
   //-----------------------------------------------------------------
   hcf_swap u_swap (
      .clk_i(CLK_I),
      .rst_n_i(RESETN_I),
      .swap_dis_i(swap_dis_ff),
      .data_i(DMA_DATA_I),
      .valid_i(DMA_VALID_I),
      .outside_i(DMA_OUTSIDE_I),
      .data_o(DMA_DATA_O),
      .valid_o(DMA_VALID_O)
   );

   //-----------------------------------------------------------------
   // Outputs
   //-----------------------------------------------------------------
   // All straight from flops
   assign AVS_READDATA_O = rdata_ff;
   assign AVS_WAITREQUEST_O = wait_ff;
   assign ROM_RD_ACCEPT_O = rom_acc_ff;
   assign ROM_TYPE_ERR_O = rom_err_ff;
   assign ROM_RELOAD_O = rom_reload_ff;
   assign TARDY_ACK_O = tardy_ff;
   assign TARDY_EVENT_O = tardy_ev_ff;
   assign ASYNC_PASS_O = pass_ff;
   assign ROM_UPDATE_EN_O = img_valid_ff;
   assign LINK_CONNECT_O = link_on_ff;
   assign PHY_EXT_ON_O = phy_ext_ff;
   assign PHY_SETUP_O = phy_setup_ff;

   //-----------------------------------------------------------------
   // Checks
   //-----------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   a_set_addr_sets: assert property (
      (wr_set && wmask[`HCF_BIT_LATE] && !hw_clr) |=> late_ack_ff)
      else $error("set address did not set flag");

   a_clr_addr_clears: assert property (
      (wr_clr && wmask[`HCF_BIT_LATE] && !hw_clr) |=> !late_ack_ff)
      else $error("clear address did not clear flag");

   a_pair_read_same: assert property (
      (in_answer && AVS_READ_I && (hcf_hit(AVS_ADDRESS_I, `HCF_OFS_SET) ||
       hcf_hit(AVS_ADDRESS_I, `HCF_OFS_CLR))) |-> (AVS_READDATA_O == $past(flags_word)))
      else $error("flag read differs from flag state");

   a_company_fixed: assert property (
      (in_answer && AVS_READ_I && hcf_hit(AVS_ADDRESS_I, `HCF_OFS_COMPANY))
      |-> (AVS_READDATA_O == COMPANY_CODE))
      else $error("company code read wrong");

   a_rsvd_high_zero: assert property (
      (in_answer && AVS_READ_I && hcf_hit(AVS_ADDRESS_I, `HCF_OFS_SET))
      |-> (AVS_READDATA_O[28:24] == 5'h00))
      else $error("reserved flag bits not zero");

   a_low_half_zero: assert property (
      (in_answer && AVS_READ_I && hcf_hit(AVS_ADDRESS_I, `HCF_OFS_CLR))
      |-> (AVS_READDATA_O[15:0] == 16'h0000))
      else $error("low flag half not zero");

   a_rom_read_ok: assert property (
      (link_on_ff && LINK_EV_I.blk_rd && img_valid_ff)
      |=> (ROM_RD_ACCEPT_O && !ROM_TYPE_ERR_O))
      else $error("valid image ROM read not accepted");

   a_rom_type_err: assert property (
      (link_on_ff && LINK_EV_I.blk_rd && !img_valid_ff)
      |=> (ROM_TYPE_ERR_O && !ROM_RD_ACCEPT_O))
      else $error("invalid image ROM read not refused");

   a_no_reload: assert property (
      (LINK_EV_I.bus_reset && !img_valid_ff) |=> !ROM_RELOAD_O)
      else $error("ROM reloaded without valid image");

   a_img_sticky: assert property (
      (img_valid_ff && !hw_clr && !LINK_EV_I.fetch_err) |=> img_valid_ff)
      else $error("image valid cleared without cause");

   a_img_link_off: assert property (
      (!img_valid_ff && link_on_ff) |=> !img_valid_ff)
      else $error("image valid set while link on");

   a_tardy_answer: assert property (
      (link_on_ff && LINK_EV_I.async_req && late_ack_ff) |=> (TARDY_ACK_O && !ASYNC_PASS_O))
      else $error("ack_tardy missing");

   a_tardy_event: assert property (
      TARDY_ACK_O |-> TARDY_EVENT_O)
      else $error("ack_tardy without event");

   a_phy_setup_load: assert property (
      EE_LOAD_I |=> (PHY_SETUP_O == $past(EE_PHY_SETUP_I)))
      else $error("PHY setup bit not loaded");

   a_phy_setup_kept: assert property (
      !EE_LOAD_I |=> $stable(phy_setup_ff))
      else $error("PHY setup bit changed without load");

   a_link_off_quiet: assert property (
      !link_on_ff |=> !(ROM_RD_ACCEPT_O || ROM_TYPE_ERR_O || TARDY_ACK_O || ASYNC_PASS_O))
      else $error("traffic handled while link off");

   a_wait_answer: assert property (
      (bus_st_ff == BS_IDLE && req) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
      else $error("waitrequest answer not one cycle");

endmodule

// >>> hcf_remote_node.sv
// Remote serial bus node model that fires link event pulses
`timescale 1ns/1ns
module hcf_remote_node
   import hcf_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Events toward the flag bank
   output hcf_link_ev_t ev_o
);
   // Quiet between packets, so a stuck event line shows up at once
   initial ev_o = '0;

   // One packet or bus event after gap idle cycles, one cycle long
   task automatic send(input logic [1:0] kind, input int gap);
      logic [3:0] v;
      v = 4'(4'h1 << kind);
      repeat (gap) @(posedge clk_i);
      ev_o <= hcf_link_ev_t'(v);
      @(posedge clk_i);
      ev_o <= '0;
   endtask
endmodule

// >>> hcf_regs_tb_top.sv
// Self-checking bench of the host control flag bank
`timescale 1ns/1ns
module hcf_regs_tb_top
   import hcf_pkg::*;
;
   // Arbitrary value, stands in for a maker code
   localparam logic [31:0] CODE = 32'h5a3c_0f11;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_rst = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h0;
   logic ee_ld = 1'b0;
   logic ee_val = 1'b0;
   logic [31:0] dma_d = 32'h0;
   logic dma_v = 1'b0;
   logic dma_out = 1'b0;
   wire [31:0] rdat;
   wire wait_q;
   wire [31:0] dma_q;
   wire dma_vq;
   wire [5:0] resp;
   wire [3:0] lvl;
   hcf_link_ev_t ev;
   int bad_count = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h0000_003e;
   logic [31:0] got;
   logic e_img, e_swap, e_late, e_pset, e_pext, e_link;

   // Free-running 50 MHz clock
   always #10 clk = ~clk;

   hcf_remote_node i_hcf_remote_node (.clk_i(clk), .ev_o(ev));

   hcf_regs #(.COMPANY_CODE(CODE)) i_hcf_regs (
      .CLK_I(clk), .RESETN_I(rst_n), .SYS_RESET_I(sys_rst),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_q),
      .LINK_EV_I(ev), .EE_LOAD_I(ee_ld), .EE_PHY_SETUP_I(ee_val),
      .DMA_DATA_I(dma_d), .DMA_VALID_I(dma_v), .DMA_OUTSIDE_I(dma_out),
      .DMA_DATA_O(dma_q), .DMA_VALID_O(dma_vq),
      .ROM_RD_ACCEPT_O(resp[5]), .ROM_TYPE_ERR_O(resp[4]), .ROM_RELOAD_O(resp[3]),
      .TARDY_ACK_O(resp[2]), .TARDY_EVENT_O(resp[1]), .ASYNC_PASS_O(resp[0]),
      .ROM_UPDATE_EN_O(lvl[3]), .LINK_CONNECT_O(lvl[2]),
      .PHY_EXT_ON_O(lvl[1]), .PHY_SETUP_O(lvl[0])
   );

   //------------
   // Helpers
   //------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected flag word, unused bits zero
   function automatic logic [31:0] flags();
      return {e_img, e_swap, e_late, 5'h00, e_pset, e_pext, 4'h0, e_link, 17'h00000};
   endfunction

   // Blocks read, async, bus reset, fetch error; order accept..pass
   function automatic logic [5:0] exp_resp(input logic [1:0] k);
      case (k)
         2'd3: return e_link ? {e_img, ~e_img, 4'h0} : 6'h00;
         2'd2: return e_link ? {3'h0, e_late, e_late, ~e_late} : 6'h00;
         2'd1: return {2'h0, e_img, 3'h0};
         default: return 6'h00;
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   // Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      be <= b;
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      @(posedge clk);
      while (wait_q !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) bad_count++;
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   // Write at set or clear address and track the expected flags
   task automatic wr_flags(input logic clr, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] m;
      m = d & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      bus(1'b1, clr ? 8'h54 : 8'h50, d, b);
      if (clr) begin
         {e_swap, e_late} = {e_swap & ~m[30], e_late & ~m[29]};
         {e_pext, e_link} = {e_pext & ~m[22], e_link & ~m[17]};
      end else begin
         e_img = e_img | (m[31] & ~e_link);
         {e_swap, e_late} = {e_swap | m[30], e_late | m[29]};
         {e_pext, e_link} = {e_pext | m[22], e_link | m[17]};
      end
   endtask

   task automatic check_all();
      bus(1'b0, 8'h50, 32'h0, 4'hf);
      chk("set view", flags(), got);
      bus(1'b0, 8'h54, 32'h0, 4'hf);
      chk("clear view", flags(), got);
      chk("levels", {28'h0, e_img, e_link, e_pext, e_pset}, {28'h0, lvl});
   endtask

   // One event, then all six pulses compared in the cycle they stand
   task automatic event_chk(input logic [1:0] k, input int gap);
      i_hcf_remote_node.send(k, gap);
      @(posedge clk);
      chk("response", 32'(exp_resp(k)), 32'(resp));
      if (k == 2'd0) e_img = 1'b0;
   endtask

   task automatic dma_chk(input logic [31:0] d, input logic o);
      dma_d <= d;
      dma_out <= o;
      dma_v <= 1'b1;
      @(posedge clk);
      dma_v <= 1'b0;
      @(posedge clk);
      chk("dma data", (o && !e_swap) ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d, dma_q);
      chk("dma valid", 32'h1, {31'h0, dma_vq});
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      {e_img, e_swap, e_late, e_pset, e_pext, e_link} = 6'b000100;
   endtask

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   //------------
   // Stimulus
   //------------
   initial begin
      logic [31:0] r;
      do_reset();
      check_all();
      bus(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
      bus(1'b1, 8'h44, 32'hffff_ffff, 4'hf);
      bus(1'b0, 8'h40, 32'h0, 4'hf);
      chk("company code", CODE, got);
      bus(1'b0, 8'h44, 32'h0, 4'hf);
      chk("unmapped", 32'h0, got);
      // Image valid refused while link on, then taken with link off
      wr_flags(1'b0, 32'h0002_0000, 4'hf);
      wr_flags(1'b0, 32'h8000_0000, 4'hf);
      check_all();
      wr_flags(1'b1, 32'hffff_ffff, 4'hf);
      wr_flags(1'b0, 32'h8000_0000, 4'hf);
      wr_flags(1'b0, 32'h6042_0000, 4'hf);
      check_all();
      for (int k = 3; k >= 0; k--) event_chk(2'(k), 0);
      // Random writes, events and data words; soft reset bit kept clear
      for (int i = 0; i < 40; i++) begin
         seed = nxt(seed);
         r = seed;
         r[16] = 1'b0;
         if (r[31]) r[17] = 1'b0;
         wr_flags(seed[5], r, seed[9:6]);
         check_all();
         seed = nxt(seed);
         event_chk(seed[1:0], int'(seed[3:2]));
         dma_chk(seed, seed[4]);
      end
      // Loaded setup bit survives system reset
      ee_val <= 1'b0;
      ee_ld <= 1'b1;
      @(posedge clk);
      ee_ld <= 1'b0;
      @(posedge clk);
      e_pset = 1'b0;
      wr_flags(1'b1, 32'h0002_0000, 4'hf);
      wr_flags(1'b0, 32'h8000_0000, 4'hf);
      wr_flags(1'b0, 32'h6042_0000, 4'hf);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      {e_img, e_late, e_pext, e_link} = 4'h0;
      check_all();
      // Soft reset clears the same flags, image valid included
      wr_flags(1'b0, 32'he042_0000, 4'hf);
      check_all();
      bus(1'b1, 8'h50, 32'h0001_0000, 4'hf);
      repeat (2) @(posedge clk);
      {e_img, e_late, e_pext, e_link} = 4'h0;
      check_all();
      do_reset();
      check_all();
      final_report();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule
